// file: design/pcl_cfg.svh
// Offsets, field positions, reset values and counts for the lock block
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH

// Register byte addresses
`define PCL_OFF_PERIPH_CFG   32'h01B3_F000
`define PCL_OFF_DEV_STATUS   32'h01B3_F004
`define PCL_OFF_CFG_LOCK     32'h01B3_F018

// Unlock key and lock status reset value
`define PCL_UNLOCK_KEY       32'h10C0_010C
`define PCL_LOCK_RESET       1'b1

// Peripheral configuration fields
`define PCL_CFG_WIDTH        7
`define PCL_CFG_RESET        7'h06
`define PCL_CFG_AUDIO_SEL    0
`define PCL_CFG_SER0_SEL     1
`define PCL_CFG_SER1_SEL     2
`define PCL_CFG_TWI_EN       3
`define PCL_CFG_VPA_EN       4
`define PCL_CFG_VPB_EN       5
`define PCL_CFG_VPC_EN       6

// Device status fields
`define PCL_STAT_PCI_EN      8
`define PCL_STAT_AUTOINIT    9
`define PCL_STAT_HOST_WIDE   10
`define PCL_STAT_ETH_EN      11
`define PCL_STRAP_RESET      4'h0

// Timing counts in clock cycles
`define PCL_SETTLE_CYCLES    128
`define PCL_COMMIT_CYCLES    4

`endif

// file: design/pcl_pkg.sv
// Types shared by the configuration lock block
package pcl_pkg;
  typedef enum logic [0:0] {
    PCL_IDLE = 1'b0,
    PCL_PEND = 1'b1
  } pcl_commit_state_t;
endpackage

// file: design/pcl_cfg_if.sv
// Posted-write channel between bus slave and configuration store
`timescale 1ns/100ps
`include "pcl_cfg.svh"
interface pcl_cfg_if;
  logic                        postValid;
  logic [`PCL_CFG_WIDTH-1:0]   postData;
  logic                        postAllowed;
  logic                        busy;
  logic [`PCL_CFG_WIDTH-1:0]   cfgValue;
  modport slave  (output postValid, postData, postAllowed,
                  input busy, cfgValue);
  modport store  (input postValid, postData, postAllowed,
                  output busy, cfgValue);
endinterface

// file: design/pcl_cfg_store.sv
// Configuration register with delayed commit of posted writes
`timescale 1ns/100ps
`include "pcl_cfg.svh"
module pcl_cfg_store
  import pcl_pkg::*;
#(
  parameter int COMMIT_CYCLES = `PCL_COMMIT_CYCLES
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Posted write channel
  pcl_cfg_if.store    cfgBus
);
  localparam int CW = $clog2(COMMIT_CYCLES + 1);

  pcl_commit_state_t          state;
  logic [CW-1:0]              delay;
  logic [`PCL_CFG_WIDTH-1:0]  heldData;
  logic                       heldAllowed;
  logic [`PCL_CFG_WIDTH-1:0]  cfgReg;
  logic                       commitNow;

  assign commitNow = (state == PCL_PEND) && (delay == CW'(1));
  assign cfgBus.busy = (state == PCL_PEND);
  assign cfgBus.cfgValue = cfgReg;

  // Write lands some cycles after the bus accepted it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= PCL_IDLE;
      delay <= '0;
      heldData <= '0;
      heldAllowed <= 1'b0;
    end else begin
      case (state)
        PCL_IDLE: begin
          if (cfgBus.postValid) begin
            state <= PCL_PEND;
            delay <= CW'(COMMIT_CYCLES);
            heldData <= cfgBus.postData;
            heldAllowed <= cfgBus.postAllowed;
          end
        end
        PCL_PEND: begin
          delay <= delay - CW'(1);
          if (commitNow) begin
            state <= PCL_IDLE;
          end
        end
        default: state <= PCL_IDLE;
      endcase
    end
  end

  // Locked writes still pass through, but leave contents alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReg <= `PCL_CFG_RESET; // R01
    end else if (commitNow && heldAllowed) begin // R05
      cfgReg <= heldData;
    end
  end
endmodule // pcl_cfg_store

// file: design/pcl_lock_top.sv
// Contract
// R01 - Audio, video and two-wire units stay disabled after reset until enabled.
// R02 - Software sets a peripheral's enable bit before using that peripheral.
// R03 - Writing key 0x10C0010C to lock register clears lock, allows next write.
// R04 - Lock register reads lock status in bit 0; upper bits zero.
// R05 - Lock resets to one; locked configuration writes change nothing.
// R06 - Configuration reads return contents whatever the lock status.
// R07 - Every configuration write sets the lock again.
// R08 - Software enables all needed peripherals in one configuration write.
// R09 - Configuration read after a write stalls until that write lands.
// R10 - Software reads configuration back before counting the enable wait.
// R11 - Masters wait 128 cycles after enabling before accessing a peripheral.
// R12 - No accesses to disabled peripherals; drain accesses before disabling.
// R13 - Software leaves multiplexed pins alone while the system runs.
// R14 - Device status reports peripheral selection read-only; bits 31:12 zero.
// R15 - Status bit 11 shows ethernet enable, zero meaning disabled.
// R16 - Ethernet enable has no effect while PCI enable status is one.
// R17 - Status bit 10 shows host port width, zero 16-bit, one 32-bit.
// R18 - Status bit 9 shows PCI serial memory autoinit, zero meaning off.
// R19 - Config bits 6..3 enable video ports c, b, a and two-wire unit.
// R20 - Config bit 0 gives pins to audio port, else to video upper data.
// R21 - Lock writes with any other value leave the lock status unchanged.
`timescale 1ns/100ps
`include "pcl_cfg.svh"
module pcl_lock_top
  import pcl_pkg::*;
#(
  parameter int SETTLE_CYCLES = `PCL_SETTLE_CYCLES,
  parameter int COMMIT_CYCLES = `PCL_COMMIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Straps sampled once after reset
  input  wire logic        strapPciEnable,
  input  wire logic        strapAutoinit,
  input  wire logic        strapHostWide,
  input  wire logic        strapEthernet,
  // Peripheral enables and pin selects
  output logic             audioPortPinSelect,
  output logic             serialPort0Select,
  output logic             serialPort1Select,
  output logic             twoWireEnable,
  output logic             videoPortAEnable,
  output logic             videoPortBEnable,
  output logic             videoPortCEnable,
  // Device selection status
  output logic             ethernetEnable,
  output logic             hostPortWide,
  output logic             pciSerialMemAutoinit,
  output logic             pciEnable,
  // Lock and settle status
  output logic             lockStatus,
  output logic [4:0]       peripheralSettled
);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  // Full-word compare of a bus address against a register offset
  function automatic logic regHit(input logic [31:0] addr,
                                  input logic [31:0] off);
    regHit = (addr == off);
  endfunction

  // Decode and bus handshake
  logic        hitCfg;
  logic        hitStat;
  logic        hitLock;
  logic        cfgStall;
  logic        readReady;
  logic        writeAccept;
  logic        keyMatch;
  logic [31:0] next_readdata;

  // Latched straps and derived status word
  logic        strapTaken;
  logic [3:0]  straps;
  logic [31:0] devStatus;

  // Settle tracking per enable
  logic [4:0]  enables;

  pcl_cfg_if cfgBus ();

  // Configuration store with posted commit
  pcl_cfg_store #(
    .COMMIT_CYCLES (COMMIT_CYCLES)
  ) pcl_cfg_store_inst (
    .clk     (clk),
    .reset_n (reset_n),
    .cfgBus  (cfgBus.store)
  );

  // Address decode, shared by read mux and write path
  assign hitCfg  = regHit(avs_address, `PCL_OFF_PERIPH_CFG);
  assign hitStat = regHit(avs_address, `PCL_OFF_DEV_STATUS);
  assign hitLock = regHit(avs_address, `PCL_OFF_CFG_LOCK);

  // Any config access waits while a posted write is in flight
  assign cfgStall = hitCfg && cfgBus.busy; // R09

  // Reads take two cycles so readdata comes from a flop;
  // writes finish at once unless stalled behind a commit
  always_comb begin
    if (avs_read) begin
      avs_waitrequest = ~readReady;
    end else begin
      avs_waitrequest = avs_write & cfgStall;
    end
  end

  assign writeAccept = avs_write & ~avs_waitrequest;

  // Key only counts as a full 32-bit word write
  assign keyMatch = (avs_writedata == `PCL_UNLOCK_KEY) &&
                    (avs_byteenable == 4'hF);

  // Status word: reserved and unknown bits read zero
  always_comb begin
    devStatus = 32'h0000_0000; // R14
    devStatus[`PCL_STAT_PCI_EN]    = straps[0];
    devStatus[`PCL_STAT_AUTOINIT]  = straps[1]; // R18
    devStatus[`PCL_STAT_HOST_WIDE] = straps[2]; // R17
    // Reports the selection in force, so PCI masks ethernet here too
    devStatus[`PCL_STAT_ETH_EN]    = straps[3] & ~straps[0]; // R15 R16
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hitCfg) begin
      next_readdata[`PCL_CFG_WIDTH-1:0] = cfgBus.cfgValue; // R06
    end else if (hitStat) begin
      next_readdata = devStatus;
    end else if (hitLock) begin
      next_readdata[0] = lockStatus; // R04
    end
  end

  // Capture read data, for config reads once no commit is pending, then release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readReady <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !readReady && !cfgStall) begin
      readReady <= 1'b1;
      avs_readdata <= next_readdata; // R09
    end else if (avs_read && readReady) begin
      readReady <= 1'b0;
    end
  end

  // Lock status: key unlocks, config write relocks, else holds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockStatus <= `PCL_LOCK_RESET; // R05
    end else if (writeAccept && hitLock && keyMatch) begin
      lockStatus <= 1'b0; // R03
    end else if (writeAccept && hitCfg) begin
      lockStatus <= 1'b1; // R07
    end
  end
  // Other lock values fall through above and change nothing // R21

  // Post config writes; permission is fixed at acceptance so
  // the relock in the same edge cannot veto this write
  assign cfgBus.postValid   = writeAccept & hitCfg;
  assign cfgBus.postData    = avs_writedata[`PCL_CFG_WIDTH-1:0];
  assign cfgBus.postAllowed = ~lockStatus & avs_byteenable[0]; // R05

  // Straps caught at the first edge after reset release; never
  // loaded under the asynchronous reset itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapTaken <= 1'b0;
      straps <= `PCL_STRAP_RESET;
    end else if (!strapTaken) begin
      strapTaken <= 1'b1;
      straps <= {strapEthernet, strapHostWide,
                 strapAutoinit, strapPciEnable};
    end
  end

  // Selection status outputs
  assign pciEnable            = straps[0];
  assign pciSerialMemAutoinit = straps[1]; // R18
  assign hostPortWide         = straps[2]; // R17
  // PCI owns the shared pins, so ethernet is masked off
  assign ethernetEnable       = straps[3] & ~straps[0]; // R16

  // Peripheral enables straight from the stored configuration
  assign audioPortPinSelect = cfgBus.cfgValue[`PCL_CFG_AUDIO_SEL]; // R20
  assign serialPort0Select  = cfgBus.cfgValue[`PCL_CFG_SER0_SEL];
  assign serialPort1Select  = cfgBus.cfgValue[`PCL_CFG_SER1_SEL];
  assign twoWireEnable      = cfgBus.cfgValue[`PCL_CFG_TWI_EN]; // R19
  assign videoPortAEnable   = cfgBus.cfgValue[`PCL_CFG_VPA_EN]; // R19
  assign videoPortBEnable   = cfgBus.cfgValue[`PCL_CFG_VPB_EN]; // R19
  assign videoPortCEnable   = cfgBus.cfgValue[`PCL_CFG_VPC_EN]; // R19

  assign enables = {videoPortCEnable, videoPortBEnable,
                    videoPortAEnable, twoWireEnable,
                    audioPortPinSelect};

  // Settle flag per unit: rises after the enable held for the
  // wait period; a hint to masters, it blocks nothing itself
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_settle
      logic [SW-1:0] count;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          count <= '0;
        end else if (!enables[gi]) begin
          count <= '0;
        end else if (count != SW'(SETTLE_CYCLES)) begin
          count <= count + SW'(1); // R11
        end
      end
      assign peripheralSettled[gi] = (count == SW'(SETTLE_CYCLES));
    end
  endgenerate
endmodule // pcl_lock_top

// file: sim/pcl_lock_properties.sv
// Port-level checks for the configuration lock block
`timescale 1ns/100ps
`include "pcl_cfg.svh"
module pcl_lock_props #(
  parameter int SETTLE_CYCLES = 128
) (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Enables, status and lock
  input wire logic        audioPortPinSelect,
  input wire logic        serialPort0Select,
  input wire logic        serialPort1Select,
  input wire logic        twoWireEnable,
  input wire logic        videoPortAEnable,
  input wire logic        videoPortBEnable,
  input wire logic        videoPortCEnable,
  input wire logic        ethernetEnable,
  input wire logic        hostPortWide,
  input wire logic        pciSerialMemAutoinit,
  input wire logic        pciEnable,
  input wire logic        lockStatus,
  input wire logic [4:0]  peripheralSettled
);
  // Settle window, slack of one cycle early and two cycles late around the settle count
  localparam int SLO = SETTLE_CYCLES - 1;
  localparam int SHI = SETTLE_CYCLES + 2;
  // Accepted transfers and the enable vector in register order
  wire logic wrOk = avs_write && !avs_waitrequest;
  wire logic rdOk = avs_read && !avs_waitrequest;
  wire logic lockAdr = avs_address == `PCL_OFF_CFG_LOCK;
  wire logic cfgAdr = avs_address == `PCL_OFF_PERIPH_CFG;
  wire logic [6:0] enVec = {videoPortCEnable, videoPortBEnable,
    videoPortAEnable, twoWireEnable, serialPort1Select,
    serialPort0Select, audioPortPinSelect};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  key_unlock_a: assert property (
    wrOk && lockAdr && avs_writedata == `PCL_UNLOCK_KEY
    && avs_byteenable == 4'hF |=> !lockStatus) else $error("key ignored");
  bad_key_a: assert property (
    wrOk && lockAdr && avs_writedata != `PCL_UNLOCK_KEY
    |=> $stable(lockStatus)) else $error("wrong key moved lock");
  cfg_relock_a: assert property (
    wrOk && cfgAdr |=> lockStatus) else $error("no relock");
  locked_hold_a: assert property (
    wrOk && cfgAdr && lockStatus |=> $stable(enVec)[*5])
    else $error("locked write changed enables");
  lock_read_a: assert property (
    rdOk && lockAdr |-> avs_readdata == {31'h0, lockStatus})
    else $error("lock readback wrong");
  stat_read_a: assert property (
    rdOk && avs_address == `PCL_OFF_DEV_STATUS |-> avs_readdata == {20'h0,
    ethernetEnable, hostPortWide, pciSerialMemAutoinit, pciEnable, 8'h0})
    else $error("status readback wrong");
  eth_gate_a: assert property (
    pciEnable |-> !ethernetEnable) else $error("ethernet on with pci");
  cfg_read_a: assert property (
    rdOk && cfgAdr |-> avs_readdata == {25'h0, enVec})
    else $error("config readback wrong");
  settle_a: assert property (
    $rose(videoPortAEnable) |-> ##[SLO:SHI] peripheralSettled[2])
    else $error("settle late");
endmodule // pcl_lock_props

bind pcl_lock_top pcl_lock_props #(.SETTLE_CYCLES(SETTLE_CYCLES))
  pcl_lock_props_inst (.clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .audioPortPinSelect, .serialPort0Select,
  .serialPort1Select, .twoWireEnable, .videoPortAEnable,
  .videoPortBEnable, .videoPortCEnable, .ethernetEnable, .hostPortWide,
  .pciSerialMemAutoinit, .pciEnable, .lockStatus, .peripheralSettled);

// file: sim/pcl_lock_top_tb.sv
// Self-checking bench for the configuration lock block
`timescale 1ns/100ps
`include "pcl_cfg.svh"
module pcl_lock_top_tb;
  localparam int SETTLE = 8;
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] avs_address = 32'h0000_0000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [3:0]  straps = 4'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [6:0]  enOut;
  wire  [3:0]  statOut;
  wire  [4:0]  settled;
  wire         lockStatus;
  int          checks = 0;
  int          fail_count = 0;

  pcl_lock_top #(.SETTLE_CYCLES(SETTLE)) pcl_lock_top_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .strapPciEnable(straps[0]), .strapAutoinit(straps[1]),
    .strapHostWide(straps[2]), .strapEthernet(straps[3]),
    .audioPortPinSelect(enOut[0]), .serialPort0Select(enOut[1]),
    .serialPort1Select(enOut[2]), .twoWireEnable(enOut[3]),
    .videoPortAEnable(enOut[4]), .videoPortBEnable(enOut[5]),
    .videoPortCEnable(enOut[6]), .ethernetEnable(statOut[3]),
    .hostPortWide(statOut[2]), .pciSerialMemAutoinit(statOut[1]),
    .pciEnable(statOut[0]), .lockStatus(lockStatus),
    .peripheralSettled(settled));

  // Free-running 25 MHz clock
  always #20 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One transfer; held until waitrequest is seen low, so no cycle count;
  // only the watchdog ends a hung wait
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Status word as the straps dictate; ethernet masked by pci
  function automatic logic [31:0] expStat(input logic [3:0] s);
    return {20'h0, s[3] & ~s[0], s[2], s[1], s[0], 8'h00};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #400000;
    fail_count++;
    summarize();
  end

  // Main sequence; second pass resets mid-run with pci and ethernet set
  initial begin
    logic [31:0] q;
    logic [31:0] d;
    logic [31:0] e;
    logic [3:0]  be;
    logic [6:0]  cfg;
    logic [2:0]  pins;
    void'($urandom(98));
    for (int p = 0; p < 2; p++) begin
      straps <= p ? 4'h9 : 4'($urandom);
      reset_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      e = expStat(straps);
      chk({20'h0, statOut, 8'h0}, e);
      chk(enOut, 7'h06);
      chk(lockStatus, 1'b1);
      bus(1'b0, `PCL_OFF_CFG_LOCK, 0, 4'hF, q);
      chk(q, 32'h0000_0001);
      bus(1'b1, `PCL_OFF_PERIPH_CFG, $urandom, 4'hF, q);
      bus(1'b0, `PCL_OFF_PERIPH_CFG, 0, 4'hF, q);
      chk(q, 32'h0000_0006);
      bus(1'b1, `PCL_OFF_CFG_LOCK, `PCL_UNLOCK_KEY ^ ($urandom | 1), 4'hF, q);
      bus(1'b0, `PCL_OFF_CFG_LOCK, 0, 4'hF, q);
      chk(q, 32'h0000_0001);
      bus(1'b1, `PCL_OFF_DEV_STATUS, $urandom, 4'hF, q);
      bus(1'b0, `PCL_OFF_DEV_STATUS, 0, 4'hF, q);
      chk(q, e);
      bus(1'b0, 32'h01B3_F008, 0, 4'hF, q);
      chk(q, 32'h0000_0000);
      cfg = 7'h06;
      // Pin selects chosen once per pass; in pass 1 the first allowed write switches them from the reset value
      pins = p ? 3'b001 : 3'b110;
      // No peripheral traffic, so none is cut off by a disable
      // Random unlock and write rounds, some with lane 0 off
      repeat (6) begin
        be = ($urandom & 1) ? 4'hF : 4'hE;
        // All wanted enables go in one write
        d = ($urandom & 32'hFFFF_FFF8) | {29'h0, pins};
        bus(1'b1, `PCL_OFF_CFG_LOCK, `PCL_UNLOCK_KEY, 4'hF, q);
        bus(1'b0, `PCL_OFF_CFG_LOCK, 0, 4'hF, q);
        chk(q, 32'h0000_0000);
        bus(1'b1, `PCL_OFF_PERIPH_CFG, d, be, q);
        if (be[0]) cfg = d[6:0];
        bus(1'b0, `PCL_OFF_PERIPH_CFG, 0, 4'hF, q);
        chk(q, {25'h0, cfg});
        bus(1'b0, `PCL_OFF_CFG_LOCK, 0, 4'hF, q);
        chk(q, 32'h0000_0001);
        chk(enOut, cfg);
        repeat (SETTLE + 2) @(posedge clk);
        chk(settled, {cfg[6:3], cfg[0]});
      end
      $display("test %0d done", p);
    end
    summarize();
  end
endmodule // pcl_lock_top_tb
